// ==== hdl/sent_pkg.sv ====
// ----------------------------------------------------------------------------
// shared constants for the single-wire nibble transmitter
// ----------------------------------------------------------------------------
package sent_pkg;
  // clock and tick unit
  localparam int CLK_MHZ        = 125;                          // system clock rate
  localparam int TICK_US_X100   = 275;                          // tick length 2.75 us, in hundredths
  localparam int TICK_CYC       = TICK_US_X100 * CLK_MHZ / 100; // 343 clocks per tick
  // pulse shapes in ticks
  localparam int LOW_TICKS      = 5;                            // low phase of every pulse
  localparam int SYNC_TICKS     = 56;                           // calibration pulse period
  localparam int NIB_BASE_TICKS = 12;                           // nibble period for value zero
  localparam int NIB_MAX_TICKS  = 27;                           // nibble period for value fifteen
  localparam int MSG_MIN_TICKS  = 116;                          // shortest message
  localparam int MSG_MAX_TICKS  = 176;                          // longest message figure
  localparam int PAUSE_MIN_TICKS = 12;                          // shortest pause
  localparam int PAUSE_MAX_TICKS = 70;                          // longest pause
  localparam int PAUSE_TICKS    = 12;                           // pause actually sent
  // message layout
  localparam int NIB_COUNT      = 5;                            // status, three data, check
  localparam int ANGLE_W        = 12;                           // 4096 steps per turn
  localparam logic [3:0] CRC_SEED = 4'h5;                       // check nibble start value
  localparam logic [3:0] CRC_POLY = 4'hD;                       // x^4+x^3+x^2+1, top bit implied
  // power-up delay
  localparam int STARTUP_TYP_US = 1300;                         // typical start-up time
  localparam int STARTUP_MAX_US = 1700;                         // latest start-up time
  localparam int STARTUP_CYC    = STARTUP_TYP_US * CLK_MHZ;     // 162500 clocks
  // reset values
  localparam logic LINE_IDLE    = 1'b1;                         // line rests high
  // transmitter states
  typedef enum logic [1:0] {ST_WAIT, ST_SYNC, ST_NIB, ST_PAUSE} tx_state_t;
endpackage : sent_pkg

// ==== hdl/tick_gen.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// tick enable divider: one pulse every tick
// ----------------------------------------------------------------------------
module tick_gen (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // tick enable out
  output logic      tick_en
);
  import sent_pkg::*;

  logic [8:0] div_q;  // clocks since last tick

  // free-running divider, wraps at the tick length
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_q   <= 9'h000;
      tick_en <= 1'b0;
    end else if (div_q == 9'(TICK_CYC - 1)) begin
      div_q   <= 9'h000;
      tick_en <= 1'b1;
    end else begin
      div_q   <= div_q + 9'h001;
      tick_en <= 1'b0;
    end
  end
endmodule : tick_gen

// ==== hdl/sent_tx.sv ====
`timescale 1ns/1ps
// Operation
// - all durations counted in one 2.75 us tick; tick_gen gives 343 clocks at 125 MHz, 2.744 us
// - every pulse starts low for five ticks
// - sync pulse period is 56 ticks
// - nibble period is 12 plus its value
// - nibbles last 12 to 27 ticks
// - message without pause 116 to 176 ticks; five nibbles after the sync pulse can make it up to 191 ticks
// - pause pulse of 12 to 70 ticks
// - valid output within 1.7 ms of power-up
// - angle sent as 12-bit, 4096 steps
module sent_tx #(
  parameter int STARTUP_CYCLES = sent_pkg::STARTUP_CYC  // clocks before first message
) (
  // clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rst,
  // sampled values, same clock domain
  input  wire logic [sent_pkg::ANGLE_W-1:0]  angle_in,
  input  wire logic [3:0]                    status_in,
  // line and state
  output logic                               sent_line,
  output logic                               tx_active
);
  import sent_pkg::*;

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  // one step of the 4-bit check over a nibble, msb first
  function automatic logic [3:0] crc_step(input logic [3:0] crc, input logic [3:0] nib);
    logic [3:0] c;
    logic       fb;
    c = crc;
    for (int i = 3; i >= 0; i--) begin
      fb = c[3] ^ nib[i];
      c  = {c[2:0], 1'b0} ^ (fb ? CRC_POLY : 4'h0);
    end
    return c;
  endfunction : crc_step

  // pulse length in ticks for a state and nibble value
  function automatic logic [6:0] pulse_len(input tx_state_t st, input logic [3:0] nib);
    unique case (st)
      ST_SYNC: return 7'(SYNC_TICKS);
      ST_NIB:  return 7'(NIB_BASE_TICKS) + {3'b000, nib};
      default: return 7'(PAUSE_TICKS);
    endcase
  endfunction : pulse_len

  // --------------------------------------------------------------------------
  // storage
  // --------------------------------------------------------------------------
  logic                tick_en;     // one pulse per tick
  logic [19:0]         start_cnt_q; // power-up delay counter
  logic                start_done_q;// delay elapsed
  tx_state_t           state_q;     // pulse being sent
  logic [6:0]          tcnt_q;      // ticks into current pulse
  logic [2:0]          nib_idx_q;   // nibble slot
  logic [ANGLE_W-1:0]  angle_q;     // angle held for the frame
  logic [3:0]          stat_q;      // status held for the frame
  logic [3:0]          crc_q;       // check held for the frame
  logic [3:0]          cur_nib;     // value of the current slot
  logic [6:0]          cur_len;     // length of the current pulse
  logic                pulse_end;   // last tick of current pulse
  logic                frame_go;    // a new sync pulse starts
  logic [3:0]          crc_new;     // check over incoming angle

  tick_gen u_tick (
    .sys_clk (sys_clk),
    .rst     (rst),
    .tick_en (tick_en)
  );

  // --------------------------------------------------------------------------
  // decode
  // --------------------------------------------------------------------------
  // slot value, then length and frame start
  always_comb begin
    unique case (nib_idx_q)
      3'd0:    cur_nib = stat_q;
      3'd1:    cur_nib = angle_q[11:8];
      3'd2:    cur_nib = angle_q[7:4];
      3'd3:    cur_nib = angle_q[3:0];
      default: cur_nib = crc_q;
    endcase
    cur_len   = pulse_len(state_q, cur_nib);
    pulse_end = (tcnt_q == cur_len - 7'd1);
    frame_go  = tick_en && ((state_q == ST_WAIT && start_done_q) ||
                            (state_q == ST_PAUSE && pulse_end));
    // check covers the data nibbles and a trailing zero nibble
    crc_new   = crc_step(crc_step(crc_step(crc_step(CRC_SEED, angle_in[11:8]),
                         angle_in[7:4]), angle_in[3:0]), 4'h0);
  end

  // --------------------------------------------------------------------------
  // power-up delay
  // --------------------------------------------------------------------------
  // line stays idle until the delay has run out
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      start_cnt_q  <= 20'h0_0000;
      start_done_q <= 1'b0;
    end else if (!start_done_q) begin
      if (start_cnt_q == 20'(STARTUP_CYCLES - 1)) begin
        start_done_q <= 1'b1;
      end else begin
        start_cnt_q <= start_cnt_q + 20'h0_0001;
      end
    end
  end

  // --------------------------------------------------------------------------
  // frame data capture
  // --------------------------------------------------------------------------
  // values are frozen for a whole message
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      angle_q <= 12'h000;
      stat_q  <= 4'h0;
      crc_q   <= 4'h0;
    end else if (frame_go) begin
      angle_q <= angle_in;
      stat_q  <= status_in;
      crc_q   <= crc_new;
    end
  end

  // --------------------------------------------------------------------------
  // pulse sequencer
  // --------------------------------------------------------------------------
  // steps one tick at a time through the message
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q   <= ST_WAIT;
      tcnt_q    <= 7'h00;
      nib_idx_q <= 3'd0;
    end else if (tick_en) begin
      if (frame_go) begin
        state_q   <= ST_SYNC;
        tcnt_q    <= 7'h00;
        nib_idx_q <= 3'd0;
      end else if (state_q == ST_WAIT) begin
        tcnt_q <= 7'h00;
      end else if (pulse_end) begin
        tcnt_q <= 7'h00;
        unique case (state_q)
          ST_SYNC: begin
            state_q <= ST_NIB;
          end
          ST_NIB: begin
            // last slot is the check nibble, then pause
            if (nib_idx_q == 3'(NIB_COUNT - 1)) begin
              state_q <= ST_PAUSE;
            end else begin
              nib_idx_q <= nib_idx_q + 3'd1;
            end
          end
          default: begin
            state_q <= ST_PAUSE;
          end
        endcase
      end else begin
        tcnt_q <= tcnt_q + 7'h01;
      end
    end
  end

  // --------------------------------------------------------------------------
  // line driver
  // --------------------------------------------------------------------------
  // low for the first ticks of each pulse, high otherwise
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sent_line <= LINE_IDLE;
      tx_active <= 1'b0;
    end else begin
      sent_line <= !(state_q != ST_WAIT && tcnt_q < 7'(LOW_TICKS));
      tx_active <= (state_q != ST_WAIT);
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  logic        line_prev_q; // line one clock ago
  logic        seen_q;      // a falling edge has been seen
  logic        tick_seen_q; // a tick has been seen
  logic [16:0] per_cnt_q;   // clocks since last falling edge
  logic [16:0] low_cnt_q;   // clocks line has been low
  logic [16:0] msg_cnt_q;   // clocks since sync falling edge
  logic [8:0]  gap_q;       // clocks since last tick
  tx_state_t   kind_q;      // pulse kind at last falling edge
  logic [3:0]  kval_q;      // nibble value at last falling edge
  logic        fall;
  logic        rise;

  assign fall = line_prev_q && !sent_line;
  assign rise = !line_prev_q && sent_line;

  // edge timers for the checks
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      line_prev_q <= 1'b1;
      seen_q      <= 1'b0;
      tick_seen_q <= 1'b0;
      per_cnt_q   <= 17'h0_0000;
      low_cnt_q   <= 17'h0_0000;
      msg_cnt_q   <= 17'h0_0000;
      gap_q       <= 9'h000;
      kind_q      <= ST_WAIT;
      kval_q      <= 4'h0;
    end else begin
      line_prev_q <= sent_line;
      per_cnt_q   <= fall ? 17'h0_0001 : per_cnt_q + 17'h0_0001;
      low_cnt_q   <= sent_line ? 17'h0_0000 : low_cnt_q + 17'h0_0001;
      msg_cnt_q   <= (fall && state_q == ST_SYNC) ? 17'h0_0001 : msg_cnt_q + 17'h0_0001;
      gap_q       <= tick_en ? 9'h001 : gap_q + 9'h001;
      if (tick_en) begin
        tick_seen_q <= 1'b1;
      end
      if (fall) begin
        seen_q <= 1'b1;
        kind_q <= state_q;
        kval_q <= cur_nib;
      end
    end
  end

  tick_period_a: assert property (@(posedge sys_clk) disable iff (rst)
    tick_en && tick_seen_q |-> gap_q == 9'(TICK_CYC)) else $error("tick spacing wrong");
  low_phase_a: assert property (@(posedge sys_clk) disable iff (rst)
    rise && seen_q |-> low_cnt_q == 17'(LOW_TICKS * TICK_CYC)) else $error("low phase wrong");
  sync_period_a: assert property (@(posedge sys_clk) disable iff (rst)
    fall && seen_q && kind_q == ST_SYNC |-> per_cnt_q == 17'(SYNC_TICKS * TICK_CYC))
    else $error("sync period wrong");
  nibble_period_a: assert property (@(posedge sys_clk) disable iff (rst)
    fall && seen_q && kind_q == ST_NIB
    |-> per_cnt_q == 17'((NIB_BASE_TICKS + int'(kval_q)) * TICK_CYC)) else $error("nibble period wrong");
  nibble_range_a: assert property (@(posedge sys_clk) disable iff (rst)
    fall && seen_q && kind_q == ST_NIB |-> per_cnt_q >= 17'(NIB_BASE_TICKS * TICK_CYC) &&
    per_cnt_q <= 17'(NIB_MAX_TICKS * TICK_CYC)) else $error("nibble out of range");
  message_len_a: assert property (@(posedge sys_clk) disable iff (rst)
    fall && state_q == ST_PAUSE |-> msg_cnt_q >= 17'(MSG_MIN_TICKS * TICK_CYC))
    else $error("message too short");
  pause_range_a: assert property (@(posedge sys_clk) disable iff (rst)
    fall && seen_q && kind_q == ST_PAUSE |-> per_cnt_q >= 17'(PAUSE_MIN_TICKS * TICK_CYC) &&
    per_cnt_q <= 17'(PAUSE_MAX_TICKS * TICK_CYC)) else $error("pause out of range");
  startup_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
    !start_done_q |=> sent_line && !tx_active) else $error("line moved during start-up");
  // captured values must not move between two sync starts
  angle_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    !frame_go |=> $stable(angle_q) && $stable(stat_q) && $stable(crc_q))
    else $error("frame values changed mid-message");
  frame_order_a: assert property (@(posedge sys_clk) disable iff (rst)
    state_q == ST_PAUSE && $past(state_q) == ST_NIB |-> $past(nib_idx_q) == 3'(NIB_COUNT - 1))
    else $error("pause before check nibble");
endmodule : sent_tx

// ==== test/sent_rx.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// receiver model: times falling-edge periods and low phases
// ----------------------------------------------------------------------------
module sent_rx (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // line in
  input  wire logic        sent_line,
  // measured pulse out
  output logic             pulse_done,
  output logic [15:0]      period_cyc,
  output logic [15:0]      low_cyc,
  output logic             nib_ok
);
  import sent_pkg::*;
  logic        line_q;  // line one clock back
  logic        seen_q;  // a first falling edge was seen
  logic [15:0] cnt_q;   // clocks since the last falling edge
  // edge timing, a pulse closes at the next falling edge
  always_ff @(posedge sys_clk) begin
    pulse_done <= 1'b0;
    line_q     <= sent_line;
    cnt_q      <= cnt_q + 16'h0001;
    if (rst) begin
      seen_q <= 1'b0;
      line_q <= 1'b1;
    end else if (line_q && !sent_line) begin
      pulse_done <= seen_q;
      period_cyc <= cnt_q;
      // accepted nibble window only
      nib_ok     <= (cnt_q >= 12 * TICK_CYC) && (cnt_q <= 27 * TICK_CYC);
      seen_q     <= 1'b1;
      cnt_q      <= 16'h0001;
    end else if (!line_q && sent_line) begin
      low_cyc    <= cnt_q;
    end
  end
endmodule : sent_rx

// ==== test/sent_tx_tb_top.sv ====
`timescale 1ns/1ps
module sent_tx_tb_top;
  import sent_pkg::*;
  // ----------------------------------------------------------------------------
  // signals and frame table
  // ----------------------------------------------------------------------------
  localparam int SU_CYC = 50;                      // shortened start-up count
  typedef struct packed { logic [3:0] st; logic [11:0] ang; } row_t;
  row_t        rows [2] = '{'{4'hF, 12'h000}, '{4'h0, 12'h001}};
  logic        sys_clk = 1'b0;
  logic        rst     = 1'b1;
  logic [11:0] angle_in  = 12'h000;
  logic [3:0]  status_in = 4'hF;
  logic        sent_line, tx_active, pulse_done, nib_ok;
  logic [15:0] period_cyc, low_cyc;
  int          fail_count = 0;
  int          n_compared = 0;
  sent_tx #(.STARTUP_CYCLES(SU_CYC)) uut (.sys_clk(sys_clk), .rst(rst), .angle_in(angle_in),
    .status_in(status_in), .sent_line(sent_line), .tx_active(tx_active));
  sent_rx rx (.sys_clk(sys_clk), .rst(rst), .sent_line(sent_line), .pulse_done(pulse_done),
    .period_cyc(period_cyc), .low_cyc(low_cyc), .nib_ok(nib_ok));
  // 8 ns clock
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done
  // check nibble over the data nibbles plus a zero nibble, msb first, bits fed in at the top
  function automatic logic [3:0] crc_of(input logic [11:0] a);
    logic [3:0]  c;
    logic [15:0] m;
    logic        fb;
    c = CRC_SEED;
    m = {a, 4'h0};
    for (int i = 15; i >= 0; i--) begin
      fb = c[3] ^ m[i];
      c  = {c[2:0], 1'b0};
      if (fb) begin
        c = c ^ CRC_POLY;
      end
    end
    return c;
  endfunction : crc_of
  // waits for the next measured pulse, bounded
  task automatic get_pulse(output logic [15:0] per, output logic [15:0] low, output logic ok);
    int n;
    n = 0;
    @(negedge sys_clk);
    while (pulse_done !== 1'b1 && n < 25000) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 25000) fail_count++;
    per = period_cyc;
    low = low_cyc;
    ok  = nib_ok;
  endtask : get_pulse
  // ----------------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------------
  initial begin
    logic [15:0] per, low;
    logic        ok;
    logic [3:0]  nib [5];
    int          cyc, total;
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    check(sent_line, 1);
    check(tx_active, 0);
    @(posedge sys_clk);
    rst <= 1'b0;
    cyc = 0;
    while (sent_line === 1'b1 && cyc < 1000) begin
      @(negedge sys_clk);
      cyc++;
    end
    check(cyc >= SU_CYC && cyc <= SU_CYC + TICK_CYC + 2, 1);
    check(tx_active, 1);
    // one frame per row, inputs of the next row land mid-frame and must wait
    for (int r = 0; r < 2; r++) begin
      nib = '{rows[r].st, rows[r].ang[11:8], rows[r].ang[7:4], rows[r].ang[3:0], crc_of(rows[r].ang)};
      get_pulse(per, low, ok);
      check(per, SYNC_TICKS * TICK_CYC);
      check(low, LOW_TICKS * TICK_CYC);
      total = per;
      for (int k = 0; k < 5; k++) begin
        get_pulse(per, low, ok);
        check(per, (NIB_BASE_TICKS + nib[k]) * TICK_CYC);
        check(low, LOW_TICKS * TICK_CYC);
        check(ok, 1);
        check(tx_active, 1);
        total += per;
        if (k == 0 && r == 0) begin
          @(posedge sys_clk);
          status_in <= rows[1].st;
          angle_in  <= rows[1].ang;
        end
      end
      check(total >= 116 * TICK_CYC && total <= 176 * TICK_CYC, 1);
      if (r == 0) begin
        get_pulse(per, low, ok);
        check(per, PAUSE_TICKS * TICK_CYC);
        check(per >= 12 * TICK_CYC && per <= 70 * TICK_CYC, 1);
        check(low, LOW_TICKS * TICK_CYC);
      end
    end
    // reset in mid-run while the pause pulse is low: line goes idle, start-up repeats
    check(sent_line, 0);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    check(sent_line, 1);
    check(tx_active, 0);
    @(posedge sys_clk);
    rst <= 1'b0;
    cyc = 0;
    while (sent_line === 1'b1 && cyc < 1000) begin
      @(negedge sys_clk);
      cyc++;
    end
    check(cyc >= SU_CYC && cyc <= SU_CYC + TICK_CYC + 2, 1);
    check(tx_active, 1);
    test_done();
  end
  // watchdog over the expected run length
  initial begin
    repeat (110000) @(posedge sys_clk);
    fail_count++;
    test_done();
  end
endmodule : sent_tx_tb_top
